// >>> src/gcm_pkg.sv
`default_nettype none

package gcm_pkg;

    // Register byte addresses
    localparam logic [11:0] OFF_CFG      = 12'h000;
    localparam logic [11:0] OFF_TAP      = 12'h004;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;

    // Per-channel window: paddr[11] set, channel index in [10:6], register in [5:2]
    localparam int          CH_WIN_BIT = 11;
    localparam int          CH_IDX_LSB = 6;
    localparam int          CH_REG_LSB = 2;
    localparam int          NUM_CH     = 28;

    // global_configuration fields
    localparam int          CFG_BCAST_BIT   = 4;
    localparam int          CFG_PIN_LSB     = 2;
    localparam int          CFG_CHMASK_BIT  = 1;
    localparam int          CFG_TMRMASK_BIT = 0;
    localparam logic [7:0]  CFG_WR_MASK     = 8'h1F;
    localparam logic [7:0]  CFG_RST         = 8'h03;

    // monitor_channel_select fields
    localparam int          TAP_TX_BIT      = 5;
    localparam logic [7:0]  TAP_WR_MASK     = 8'h3F;
    localparam logic [7:0]  TAP_RST         = 8'h00;
    localparam logic [4:0]  TAP_CH_FIRST    = 5'h01;
    localparam logic [4:0]  TAP_CH_LAST     = 5'h1C;

    // Interrupt status / mask bits
    localparam int          IRQ_TMR_BIT     = 0;
    localparam int          IRQ_CH_BIT      = 1;
    localparam logic [1:0]  IRQ_MASK_RST    = 2'h0;

    // One-second interval from the 25 MHz master clock
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned TIMER_PERIOD_S  = 1;
    localparam int unsigned SEC_CYCLES      = CLK_HZ * TIMER_PERIOD_S;

    typedef struct packed {
        logic [NUM_CH-1:0] wr_en;
        logic [3:0]        reg_idx;
        logic [7:0]        data;
    } gcm_chwr_s;

    typedef struct packed {
        logic       connect;
        logic       tx;
        logic [4:0] chan;
    } gcm_tap_s;

    typedef struct packed {
        logic [7:0]        cfg;
        logic [7:0]        tap_sel;
        logic [1:0]        irq_stat;
        logic [1:0]        irq_mask;
        logic [31:0]       tick_cnt;
        logic              tick;
        logic [NUM_CH-1:0] chan_irq;
        logic              irq;
        gcm_chwr_s         chwr;
        gcm_tap_s          tap;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } gcm_state_s;

endpackage

`default_nettype wire

// >>> src/gcm_global_cfg.sv
// Summary of operation
// - Broadcast bit copies channel writes to all
// - Global mask set suppresses all channel interrupts
// - Unmasked channel status raises its channel interrupt
// - Timer mask zero enables one-second interrupt
// - Select 000000 or 100000 monitors nothing
// - Codes 1 to 28 monitor receiver N
// - Codes 33 to 60 monitor transmitter N
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module gcm_global_cfg #(
    parameter int unsigned SEC_CYCLES = gcm_pkg::SEC_CYCLES
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       srst,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    // Per-channel register writes
    output gcm_pkg::gcm_chwr_s              chan_wr,
    // Per-channel interrupt sources and results
    input  wire logic [gcm_pkg::NUM_CH-1:0] chan_irq_status,
    input  wire logic [gcm_pkg::NUM_CH-1:0] chan_irq_mask,
    output logic [gcm_pkg::NUM_CH-1:0]      chan_irq,
    // Monitoring port routing
    output gcm_pkg::gcm_tap_s               tap_route,
    // Global outputs
    output logic [1:0]                      int_pin_cfg,
    output logic                            sec_tick,
    output logic                            irq
);

    gcm_pkg::gcm_state_s st_r;
    gcm_pkg::gcm_state_s st_nxt;

    logic        setup_ph;
    logic        access_ph;
    logic        in_win;
    logic [4:0]  win_ch;
    logic        hit;
    logic [7:0]  rd_byte;
    logic        wr_go;

    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable && st_r.pready;
    assign in_win    = paddr[gcm_pkg::CH_WIN_BIT];
    assign win_ch    = paddr[gcm_pkg::CH_IDX_LSB +: 5];
    // Only byte lane 0 carries data; a write without it is dropped quietly
    assign wr_go     = access_ph && pwrite && !st_r.pslverr && pstrb[0];

    always_comb begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        if (in_win) begin
            // Channel registers live in the channel blocks; reads here return zero
            hit = (win_ch < 5'(gcm_pkg::NUM_CH)) && (paddr[1:0] == 2'h0);
        end else begin
            case (paddr)
                gcm_pkg::OFF_CFG:      rd_byte = st_r.cfg;
                gcm_pkg::OFF_TAP:      rd_byte = st_r.tap_sel;
                gcm_pkg::OFF_IRQ_STAT: rd_byte = {6'h00, st_r.irq_stat};
                gcm_pkg::OFF_IRQ_MASK: rd_byte = {6'h00, st_r.irq_mask};
                default:               hit = 1'b0;
            endcase
        end
    end

    always_comb begin
        st_nxt              = st_r;
        st_nxt.pready       = 1'b0;
        st_nxt.tick         = 1'b0;
        st_nxt.chwr.wr_en   = '0;

        // Free-running one-second counter on the master clock
        if (st_r.tick_cnt == 32'(SEC_CYCLES - 1)) begin
            st_nxt.tick_cnt = 32'h00000000;
            st_nxt.tick     = 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 32'h00000001;
        end

        // Channel interrupts, global mask overrides everything
        if (st_r.cfg[gcm_pkg::CFG_CHMASK_BIT]) begin
            st_nxt.chan_irq = '0;
        end else begin
            st_nxt.chan_irq = chan_irq_status & ~chan_irq_mask;
        end

        // APB setup: answer is prepared here so that every output is a flop
        if (setup_ph) begin
            st_nxt.pready  = 1'b1;
            st_nxt.pslverr = !hit;
            st_nxt.prdata  = {24'h000000, rd_byte};
        end

        if (wr_go) begin
            if (in_win) begin
                st_nxt.chwr.reg_idx = paddr[gcm_pkg::CH_REG_LSB +: 4];
                st_nxt.chwr.data    = pwdata[7:0];
                if (st_r.cfg[gcm_pkg::CFG_BCAST_BIT]) begin
                    st_nxt.chwr.wr_en = '1;
                end else begin
                    st_nxt.chwr.wr_en = gcm_pkg::NUM_CH'(1) << win_ch;
                end
            end else begin
                case (paddr)
                    gcm_pkg::OFF_CFG:      st_nxt.cfg = pwdata[7:0] & gcm_pkg::CFG_WR_MASK;
                    gcm_pkg::OFF_TAP:      st_nxt.tap_sel = pwdata[7:0] & gcm_pkg::TAP_WR_MASK;
                    gcm_pkg::OFF_IRQ_STAT: st_nxt.irq_stat = st_r.irq_stat & ~pwdata[1:0];
                    gcm_pkg::OFF_IRQ_MASK: st_nxt.irq_mask = pwdata[1:0];
                    default:               st_nxt.cfg = st_r.cfg;
                endcase
            end
        end

        // Sticky events are set after the clear so a coincident event survives
        if (st_r.tick && !st_r.cfg[gcm_pkg::CFG_TMRMASK_BIT]) begin
            st_nxt.irq_stat[gcm_pkg::IRQ_TMR_BIT] = 1'b1;
        end
        if (|st_r.chan_irq) begin
            st_nxt.irq_stat[gcm_pkg::IRQ_CH_BIT] = 1'b1;
        end
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);

        // Monitor routing; every code outside the two channel ranges routes nothing
        st_nxt.tap.tx = st_r.tap_sel[gcm_pkg::TAP_TX_BIT];
        if (st_r.tap_sel[4:0] >= gcm_pkg::TAP_CH_FIRST
                && st_r.tap_sel[4:0] <= gcm_pkg::TAP_CH_LAST) begin
            st_nxt.tap.connect = 1'b1;
            st_nxt.tap.chan    = st_r.tap_sel[4:0];
        end else begin
            st_nxt.tap.connect = 1'b0;
            st_nxt.tap.chan    = 5'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r          <= '0;
            st_r.cfg      <= gcm_pkg::CFG_RST;
            st_r.tap_sel  <= gcm_pkg::TAP_RST;
            st_r.irq_mask <= gcm_pkg::IRQ_MASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pready      = st_r.pready;
    assign prdata      = st_r.prdata;
    assign pslverr     = st_r.pslverr;
    assign chan_wr     = st_r.chwr;
    assign chan_irq    = st_r.chan_irq;
    assign tap_route   = st_r.tap;
    assign int_pin_cfg = st_r.cfg[gcm_pkg::CFG_PIN_LSB +: 2];
    assign sec_tick    = st_r.tick;
    assign irq         = st_r.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_chan_write;
        wr_go && in_win;
    endsequence

    sequence s_cfg_write;
        wr_go && !in_win && (paddr == gcm_pkg::OFF_CFG);
    endsequence

    sequence s_tap_write;
        wr_go && !in_win && (paddr == gcm_pkg::OFF_TAP);
    endsequence

    sequence s_tick_unmasked;
        sec_tick && !st_r.cfg[gcm_pkg::CFG_TMRMASK_BIT];
    endsequence

    // Bus answer: zero wait states, one-cycle ready
    property p_setup_answer;
        setup_ph |=> pready;
    endproperty
    a_setup_answer: assert property (p_setup_answer) else $error("no ready after setup");

    property p_pready_pulse;
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("ready held too long");

    property p_unmapped_err;
        setup_ph && !hit |=> pready && pslverr;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access without error");

    property p_irq_level;
        1'b1 |-> irq == |(st_r.irq_stat & st_r.irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not status and enable");

    property p_err_no_chan_wr;
        access_ph && pslverr |=> (chan_wr.wr_en == '0);
    endproperty
    a_err_no_chan_wr: assert property (p_err_no_chan_wr) else $error("refused write reached channels");

    property p_chan_payload;
        s_chan_write |=> chan_wr.data == $past(pwdata[7:0])
            && chan_wr.reg_idx == $past(paddr[gcm_pkg::CH_REG_LSB +: 4]);
    endproperty
    a_chan_payload: assert property (p_chan_payload) else $error("channel write payload wrong");

    property p_cfg_store;
        s_cfg_write |=> st_r.cfg == ($past(pwdata[7:0]) & gcm_pkg::CFG_WR_MASK);
    endproperty
    a_cfg_store: assert property (p_cfg_store) else $error("configuration write lost");

    property p_bcast_all;
        s_chan_write ##0 st_r.cfg[gcm_pkg::CFG_BCAST_BIT] |=> (chan_wr.wr_en == '1);
    endproperty
    a_bcast_all: assert property (p_bcast_all) else $error("broadcast write missed channels");

    property p_single_ch;
        s_chan_write ##0 !st_r.cfg[gcm_pkg::CFG_BCAST_BIT]
            |=> $onehot(chan_wr.wr_en) && chan_wr.wr_en[$past(win_ch)];
    endproperty
    a_single_ch: assert property (p_single_ch) else $error("single write hit wrong channel");

    property p_no_spurious_wr;
        !wr_go |=> (chan_wr.wr_en == '0);
    endproperty
    a_no_spurious_wr: assert property (p_no_spurious_wr) else $error("channel write without access");

    property p_glb_mask;
        st_r.cfg[gcm_pkg::CFG_CHMASK_BIT] |=> (chan_irq == '0);
    endproperty
    a_glb_mask: assert property (p_glb_mask) else $error("channel irq under global mask");

    property p_ch_irq;
        !st_r.cfg[gcm_pkg::CFG_CHMASK_BIT]
            |=> chan_irq == ($past(chan_irq_status) & ~$past(chan_irq_mask));
    endproperty
    a_ch_irq: assert property (p_ch_irq) else $error("channel irq not status and not mask");

    property p_ch_irq_one;
        !st_r.cfg[gcm_pkg::CFG_CHMASK_BIT] && chan_irq_status[0] && !chan_irq_mask[0]
            |=> chan_irq[0];
    endproperty
    a_ch_irq_one: assert property (p_ch_irq_one) else $error("first channel irq missing");

    property p_chan_event;
        |chan_irq |=> st_r.irq_stat[gcm_pkg::IRQ_CH_BIT];
    endproperty
    a_chan_event: assert property (p_chan_event) else $error("channel event not latched");

    property p_tmr_set;
        s_tick_unmasked |=> st_r.irq_stat[gcm_pkg::IRQ_TMR_BIT];
    endproperty
    a_tmr_set: assert property (p_tmr_set) else $error("timer expiry not latched");

    property p_tmr_masked;
        !st_r.irq_stat[gcm_pkg::IRQ_TMR_BIT] && (!sec_tick || st_r.cfg[gcm_pkg::CFG_TMRMASK_BIT])
            |=> !st_r.irq_stat[gcm_pkg::IRQ_TMR_BIT];
    endproperty
    a_tmr_masked: assert property (p_tmr_masked) else $error("masked timer set status");

    property p_tmr_blocked;
        sec_tick && st_r.cfg[gcm_pkg::CFG_TMRMASK_BIT] && !st_r.irq_stat[gcm_pkg::IRQ_TMR_BIT]
            |=> !st_r.irq_stat[gcm_pkg::IRQ_TMR_BIT];
    endproperty
    a_tmr_blocked: assert property (p_tmr_blocked) else $error("masked expiry latched");

    property p_tick_period;
        sec_tick |-> (st_r.tick_cnt == 32'h00000000) ##1 !sec_tick;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick not at counter wrap");

    // A SEC_CYCLES of one cycle per second would make the tick a level; not supported
    property p_tick_single;
        sec_tick |=> !sec_tick;
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("tick longer than a cycle");

    property p_tick_wrap;
        st_r.tick_cnt == 32'(SEC_CYCLES - 1) |=> sec_tick;
    endproperty
    a_tick_wrap: assert property (p_tick_wrap) else $error("no tick at terminal count");

    property p_tick_bound;
        1'b1 |-> st_r.tick_cnt <= 32'(SEC_CYCLES - 1);
    endproperty
    a_tick_bound: assert property (p_tick_bound) else $error("second counter overran");

    property p_tap_off;
        (st_r.tap_sel[4:0] == 5'h00 || st_r.tap_sel[4:0] > gcm_pkg::TAP_CH_LAST)
            |=> !tap_route.connect;
    endproperty
    a_tap_off: assert property (p_tap_off) else $error("monitor connected on idle code");

    property p_tap_tx_idle;
        st_r.tap_sel[5:0] == 6'h20 |=> !tap_route.connect;
    endproperty
    a_tap_tx_idle: assert property (p_tap_tx_idle) else $error("idle transmit code connected");

    property p_tap_idle_chan;
        !tap_route.connect |-> (tap_route.chan == 5'h00);
    endproperty
    a_tap_idle_chan: assert property (p_tap_idle_chan) else $error("idle route names a channel");

    property p_tap_store;
        s_tap_write |=> st_r.tap_sel == ($past(pwdata[7:0]) & gcm_pkg::TAP_WR_MASK);
    endproperty
    a_tap_store: assert property (p_tap_store) else $error("monitor select write lost");

    property p_tap_chan_range;
        tap_route.connect |-> (tap_route.chan >= gcm_pkg::TAP_CH_FIRST)
            && (tap_route.chan <= gcm_pkg::TAP_CH_LAST);
    endproperty
    a_tap_chan_range: assert property (p_tap_chan_range) else $error("route channel out of range");

    property p_tap_rx;
        !st_r.tap_sel[gcm_pkg::TAP_TX_BIT] && st_r.tap_sel[4:0] >= gcm_pkg::TAP_CH_FIRST
            && st_r.tap_sel[4:0] <= gcm_pkg::TAP_CH_LAST
            |=> tap_route.connect && !tap_route.tx && tap_route.chan == $past(st_r.tap_sel[4:0]);
    endproperty
    a_tap_rx: assert property (p_tap_rx) else $error("receiver route wrong");

    property p_tap_tx;
        st_r.tap_sel[gcm_pkg::TAP_TX_BIT] && st_r.tap_sel[4:0] >= gcm_pkg::TAP_CH_FIRST
            && st_r.tap_sel[4:0] <= gcm_pkg::TAP_CH_LAST
            |=> tap_route.connect && tap_route.tx && tap_route.chan == $past(st_r.tap_sel[4:0]);
    endproperty
    a_tap_tx: assert property (p_tap_tx) else $error("transmitter route wrong");

    property p_tap_follow;
        1'b1 |=> tap_route.tx == $past(st_r.tap_sel[gcm_pkg::TAP_TX_BIT]);
    endproperty
    a_tap_follow: assert property (p_tap_follow) else $error("route direction stale");

    property p_tap_rsvd_hi;
        st_r.tap_sel[5:0] >= 6'h3D |=> !tap_route.connect;
    endproperty
    a_tap_rsvd_hi: assert property (p_tap_rsvd_hi) else $error("reserved high code connected");

endmodule

`default_nettype wire

// >>> sim/tb_gcm_global_cfg.sv
`timescale 1ns/100ps
`default_nettype none

module tb_gcm_global_cfg;
    localparam int unsigned SEC = 16;
    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0;
    logic [3:0]         pstrb = 4'hF;
    logic [27:0]        st = 28'h0;
    logic [27:0]        mk = 28'h0;
    logic               pready, pslverr, sec_tick, irq, er;
    logic [31:0]        prdata, rd;
    logic [27:0]        chan_irq;
    logic [1:0]         int_pin_cfg;
    gcm_pkg::gcm_chwr_s chan_wr;
    gcm_pkg::gcm_tap_s  tap_route;
    int                 n_mismatch = 0;
    int                 tests_run = 0;
    int                 cyc = 0;

    gcm_global_cfg #(.SEC_CYCLES(SEC)) uut (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .chan_wr(chan_wr),
        .chan_irq_status(st), .chan_irq_mask(mk), .chan_irq(chan_irq),
        .tap_route(tap_route), .int_pin_cfg(int_pin_cfg), .sec_tick(sec_tick), .irq(irq));

    always #20 clk = ~clk;

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Returns on the edge where pready was seen, with the request just released
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for ready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic t_reset_and_map;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h03);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h00);
        apb(1'b1, 12'h000, 32'hFF);
        apb(1'b0, 12'h000, 32'h0);
        chk({rd[7:0], 6'h0, int_pin_cfg}, {8'h1F, 8'h03});
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("test reset_and_map done");
    endtask

    task automatic t_broadcast;
        apb(1'b1, 12'h000, 32'h03);
        apb(1'b1, 12'h894, 32'h5A);
        #1;
        chk({chan_wr.wr_en, chan_wr.reg_idx}, {28'h4, 4'h5});
        chk(chan_wr.data, 8'h5A);
        apb(1'b1, 12'h000, 32'h13);
        apb(1'b1, 12'h8C8, 32'hA5);
        #1;
        chk(chan_wr.wr_en, 28'hFFFFFFF);
        apb(1'b1, 12'hF00, 32'h11);
        #1;
        chk({er, chan_wr.wr_en}, {1'b1, 28'h0});
        apb(1'b1, 12'h000, 32'h03);
        $display("test broadcast done");
    endtask

    task automatic t_chan_irq;
        st <= 28'h0000005;
        mk <= 28'h0000004;
        wait_cyc(4);
        chk({chan_irq, irq}, 29'h0);
        apb(1'b1, 12'h000, 32'h01);
        wait_cyc(3);
        chk(chan_irq, 28'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk({rd[1], irq}, 2'b10);
        apb(1'b1, 12'h00C, 32'h2);
        wait_cyc(1);
        chk(irq, 1'b1);
        @(posedge clk);
        st <= 28'h0;
        wait_cyc(3);
        apb(1'b1, 12'h008, 32'h2);
        wait_cyc(1);
        chk({chan_irq, irq}, 29'h0);
        $display("test chan_irq done");
    endtask

    task automatic t_timer;
        int n;
        apb(1'b1, 12'h000, 32'h03);
        apb(1'b1, 12'h00C, 32'h1);
        wait_cyc(2 * SEC);
        apb(1'b0, 12'h008, 32'h0);
        chk({rd[0], irq}, 2'b00);
        n = 0;
        while (sec_tick !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sec_tick !== 1'b1 && n < 100);
        chk(n, SEC);
        apb(1'b1, 12'h000, 32'h02);
        wait_cyc(SEC + 2);
        apb(1'b0, 12'h008, 32'h0);
        chk({rd[0], irq}, 2'b11);
        apb(1'b1, 12'h000, 32'h03);
        apb(1'b1, 12'h008, 32'h1);
        wait_cyc(1);
        chk(irq, 1'b0);
        $display("test timer done");
    endtask

    task automatic t_monitor;
        logic [5:0] codes [12];
        logic [4:0] ch;
        logic       conn;
        // Reserved receive codes 011101..011111 are never written
        codes = '{6'h00, 6'h20, 6'h01, 6'h1C, 6'h21, 6'h3C, 6'h0E, 6'h2E,
                  6'h1B, 6'h3B, 6'h3D, 6'h3F};
        for (int i = 0; i < 12; i++) begin
            apb(1'b1, 12'h004, {26'h0, codes[i]});
            wait_cyc(2);
            ch = codes[i][4:0];
            conn = (ch >= 5'd1) && (ch <= 5'd28);
            if (conn) begin
                chk(tap_route, {1'b1, codes[i]});
            end else begin
                chk({tap_route.connect, tap_route.chan}, 6'h0);
            end
            apb(1'b0, 12'h004, 32'h0);
            chk(rd, {26'h0, codes[i]});
        end
        $display("test monitor done");
    endtask

    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset_and_map();
        t_broadcast();
        t_chan_irq();
        t_timer();
        t_monitor();
        tally_and_finish();
    end
endmodule

`default_nettype wire
